// ### design/dtb_map.vh
/*
  Address map, field positions and sizes of the trace buffer store and readout.
  Assumes byte addressing on a 32-bit APB with one aligned word per register.
*/
`ifndef DTB_MAP_VH
`define DTB_MAP_VH
`define DTB_DEPTH 64
`define DTB_PTR_W 6
`define DTB_CNT_W 7
`define DTB_LINE_W 20
`define DTB_ADDR_W 8
// Register offsets (byte addresses)
`define DTB_OFS_WIN_LO 8'h00
`define DTB_OFS_WIN_HI 8'h04
`define DTB_OFS_CTRL 8'h08
`define DTB_OFS_STAT 8'h0C
// Control fields
`define DTB_CTRL_ARM 0
`define DTB_CTRL_SRC 1
`define DTB_CTRL_MODE_LO 2
`define DTB_CTRL_MODE_HI 3
// Trace modes
`define DTB_MODE_NORMAL 2'h0
`define DTB_MODE_LOOP 2'h1
`define DTB_MODE_DETAIL 2'h2
`define DTB_MODE_PUREPC 2'h3
// Upper field bit positions
`define DTB_F2_B3 3
`define DTB_F2_B2 2
// Window word returned while the unit is armed
`define DTB_ARMED_FILL 32'hDEADBEEF
`endif

// ### design/dtb_trace_buffer.v
/*
  Trace buffer store and APB readout window of the on-chip debug unit.
  Assumes capture strobes from the CPU tracker are synchronous to ref_clk,
  and that comparators and sequencing live elsewhere.
*/
// Behaviour
// - 64-line circular RAM, 20 bits wide
// - valid-line counter counts stored lines, saturating at 64
// - pure PC mode records every opcode PC
// - detail entry uses address then data lines
// - detail entry bumps counter twice
// - byte access: low byte data, high cleared
// - word: lower-address byte into byte1
// - line is 4-bit field over two bytes
// - detail upper field: size, rw, addr17:16
// - size flag 0 word, 1 byte
// - rw flag 0 write, 1 read
// - normal/loop upper: srcdst, vector, program_counter_bit_17:16
// - vector flag forces destination flag
// - reads need disarmed, source enable, unsecured
// - arming locks; aligned window word write while disarmed unlocks
// - byte or misaligned reads give zero
// - oldest first, counter unchanged by reads
// - pointer starts at oldest line
// - window word write while disarmed rewinds pointer to oldest
// - low word fields 1:0, then upper field
// - armed reads invalid, pointer holds
// - system reset keeps RAM and counter
// - without source enable buffer reads zero, DEADBEEF if armed
// - RAM and counter undefined after power-on
`timescale 1ns/10ps
`default_nettype none
`include "dtb_map.vh"
module dtb_trace_buffer (
  input wire ref_clk,
  input wire rst_n,
  input wire secured,
  input wire capStrobe,
  input wire [17:0] capAddr,
  input wire [15:0] capData,
  input wire capByte,
  input wire capRead,
  input wire capDest,
  input wire capVector,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  output wire armed,
  output wire [1:0] traceMode
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // circular trace RAM
  // RAM and counter have no reset, so a system reset keeps them
  // power-on leaves RAM and counter undefined
  reg [`DTB_LINE_W-1:0] traceRam [0:`DTB_DEPTH-1];
  reg [`DTB_PTR_W-1:0] wrPtr_q;
  reg [`DTB_CNT_W-1:0] validCount_q;
  reg [`DTB_PTR_W-1:0] rdPtr_q;
  reg halfSel_q;
  reg locked_q;
  reg arm_q;
  reg srcEn_q;
  reg [1:0] mode_q;
  reg dataPending_q;
  reg [15:0] pendData_q;
  reg [`DTB_CNT_W-1:0] validCount_d;
  reg [`DTB_LINE_W-1:0] wrLine;
  reg wrEn;
  reg [3:0] upper;
  reg [15:0] dataField;
  wire apbAccess;
  wire apbWrite;
  wire apbRead;
  wire fullWord;
  wire winLo;
  wire winHi;
  wire readOk;
  wire [`DTB_PTR_W-1:0] oldestPtr;
  wire [`DTB_LINE_W-1:0] rdLine;
  wire overflowed;
  wire ctrlWrite;
  wire armStart;
  wire winSel;
  wire winWrite;
  wire winRead;
  wire capTaken;
  wire [3:0] detailUpper;
  wire [3:0] pcUpper;
  wire [3:0] flowUpper;
  reg locked_d;
  reg [`DTB_PTR_W-1:0] rdPtr_d;
  reg halfSel_d;
  reg [31:0] windowWord;
  reg [31:0] readWord;
  // Readout phase of the current line
  localparam HALF_LOW = 1'b0;
  localparam HALF_HIGH = 1'b1;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apbAccess = psel & penable;
  assign apbWrite = apbAccess & pwrite;
  assign apbRead = apbAccess & ~pwrite;
  assign fullWord = (paddr[1:0] == 2'h0) & (~pwrite | (pstrb == 4'hF));
  assign winLo = (paddr == `DTB_OFS_WIN_LO);
  assign winHi = (paddr == `DTB_OFS_WIN_HI);
  assign armed = arm_q;
  assign traceMode = mode_q;
  assign readOk = ~arm_q & srcEn_q & ~secured & ~locked_q;
  assign overflowed = validCount_q[`DTB_CNT_W-1];
  // oldest line is line 0 unless the buffer has wrapped
  assign oldestPtr = overflowed ? wrPtr_q : {`DTB_PTR_W{1'b0}};
  assign rdLine = traceRam[rdPtr_q];
  assign ctrlWrite = apbWrite & fullWord & (paddr == `DTB_OFS_CTRL);
  // A session starts only on the disarmed-to-armed step, never inside reset
  assign armStart = rst_n & ctrlWrite & pwdata[`DTB_CTRL_ARM] & ~arm_q;
  assign winSel = winLo | winHi;
  assign winWrite = apbWrite & fullWord & winSel;
  assign winRead = apbRead & fullWord & winSel;
  assign capTaken = capStrobe & arm_q & srcEn_q;

  // ------------------------------------------------------------
  // Information bits
  // ------------------------------------------------------------
  // size, rw, address bits 17:16
  // size flag set for byte access
  // rw flag set for read access
  assign detailUpper = {capByte, capRead, capAddr[17:16]};
  assign pcUpper = {2'b00, capAddr[17:16]};
  // a vector is always a destination
  assign flowUpper = {capDest | capVector, capVector, capAddr[17:16]};

  // ------------------------------------------------------------
  // Line formatting
  // ------------------------------------------------------------
  always @*
  begin
    upper = 4'h0;
    dataField = 16'h0000;
    wrEn = 1'b0;
    wrLine = {`DTB_LINE_W{1'b0}};
    if (dataPending_q)
    begin
      // data line has a zero upper field
      wrEn = 1'b1;
      wrLine = {4'h0, pendData_q};
    end
    else if (capTaken)
    begin
      wrEn = 1'b1;
      if (mode_q == `DTB_MODE_DETAIL)
        upper = detailUpper;
      else if (mode_q == `DTB_MODE_PUREPC)
        upper = pcUpper;
      else
        upper = flowUpper;
      // 4-bit field over two 8-bit fields
      wrLine = {upper, capAddr[15:0]};
    end
    // byte access keeps high byte clear
    if (capByte)
      dataField = {8'h00, capData[7:0]};
    else
      dataField = capData;
  end

  // ------------------------------------------------------------
  // Capture and counter
  // ------------------------------------------------------------
  always @*
  begin
    validCount_d = validCount_q;
    // count each stored line, saturating to flag overflow
    // detail entries store twice and so count twice
    if (wrEn & ~overflowed)
      validCount_d = validCount_q + 7'h01;
  end

  always @(posedge ref_clk)
  begin
    if (wrEn)
      traceRam[wrPtr_q] <= wrLine;
    // Starting a fresh session clears the count and write pointer
    if (armStart)
      validCount_q <= {`DTB_CNT_W{1'b0}};
    else
      validCount_q <= validCount_d;
    // write pointer keeps its place across a system reset
    // otherwise the oldest line of a wrapped buffer is lost
    if (armStart)
      wrPtr_q <= {`DTB_PTR_W{1'b0}};
    else if (wrEn)
      wrPtr_q <= wrPtr_q + 6'h01;
    if (!rst_n)
    begin
      dataPending_q <= 1'b0;
      pendData_q <= 16'h0000;
    end
    else
    begin
      // address line now, data line next cycle
      dataPending_q <= ~dataPending_q & capTaken & (mode_q == `DTB_MODE_DETAIL);
      pendData_q <= dataField;
    end
  end

  // ------------------------------------------------------------
  // Readout pointer
  // ------------------------------------------------------------
  always @*
  begin
    locked_d = locked_q;
    rdPtr_d = rdPtr_q;
    halfSel_d = halfSel_q;
    if (ctrlWrite & pwdata[`DTB_CTRL_ARM])
      locked_d = 1'b1;
    // aligned window write while disarmed unlocks
    if (winWrite & ~arm_q)
    begin
      locked_d = 1'b0;
      rdPtr_d = oldestPtr;
      halfSel_d = HALF_LOW;
    end
    // only aligned word reads move the pointer
    // armed reads leave the pointer alone
    if (winRead & readOk)
    begin
      case (halfSel_q)
        HALF_LOW:
          halfSel_d = HALF_HIGH;
        HALF_HIGH:
        begin
          // advance after the upper field word
          rdPtr_d = rdPtr_q + 6'h01;
          halfSel_d = HALF_LOW;
        end
        default:
          halfSel_d = HALF_LOW;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      arm_q <= 1'b0;
      srcEn_q <= 1'b0;
      mode_q <= `DTB_MODE_NORMAL;
      locked_q <= 1'b1;
      rdPtr_q <= 6'h00;
      halfSel_q <= HALF_LOW;
    end
    else
    begin
      if (ctrlWrite)
      begin
        arm_q <= pwdata[`DTB_CTRL_ARM];
        srcEn_q <= pwdata[`DTB_CTRL_SRC];
        mode_q <= pwdata[`DTB_CTRL_MODE_HI:`DTB_CTRL_MODE_LO];
      end
      locked_q <= locked_d;
      rdPtr_q <= rdPtr_d;
      halfSel_q <= halfSel_d;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always @*
  begin
    windowWord = 32'h00000000;
    // low word then upper field in bits 3:0
    case (halfSel_q)
      HALF_LOW:
        windowWord = {16'h0000, rdLine[15:0]};
      HALF_HIGH:
        windowWord = {28'h0000000, rdLine[19:16]};
      default:
        windowWord = 32'h00000000;
    endcase
  end

  always @*
  begin
    readWord = 32'h00000000;
    case (paddr)
      `DTB_OFS_CTRL:
        readWord = {28'h0000000, mode_q, srcEn_q, arm_q};
      `DTB_OFS_STAT:
        readWord = {16'h0000, 7'h00, locked_q, 1'b0, validCount_q};
      `DTB_OFS_WIN_LO, `DTB_OFS_WIN_HI:
      begin
        if (readOk)
          readWord = windowWord;
        else if (arm_q)
          readWord = `DTB_ARMED_FILL;
      end
      default:
        // misaligned and unmapped reads give zero
        readWord = 32'h00000000;
    endcase
  end

  // oldest first; counter untouched by reads
  // Loaded at the setup edge so a zero-wait access phase sees settled data
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata <= readWord;
  end
endmodule // dtb_trace_buffer
`default_nettype wire

// ### test/dtb_trace_checker.sv
/* Checker of the trace buffer readout window at the top ports.
   Assumes zero-wait APB and prdata loaded at the setup edge. */
`timescale 1ns/10ps
`default_nettype none
module dtb_trace_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic secured,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic armed,
  input wire logic [1:0] traceMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Bus phases
  // ----
  sequence rdSetup;
    psel && !penable && !pwrite;
  endsequence
  sequence ctrlWr;
    psel && penable && pwrite && paddr == 8'h08 && pstrb == 4'hF;
  endsequence
  a_armed_filler: assert property (rdSetup ##0 (armed && !secured && paddr[7:3] == 5'h00
    && paddr[1:0] == 2'h0) |=> prdata == 32'hDEADBEEF) else $error("armed read filler wrong");
  a_misaligned_zero: assert property (rdSetup ##0 (!armed && paddr[1:0] != 2'h0)
    |=> prdata == 32'h0) else $error("misaligned read not zero");
  a_secured_zero: assert property (rdSetup ##0 (secured && !armed && paddr[7:3] == 5'h00)
    |=> prdata == 32'h0) else $error("secured read not zero");
  a_word_width: assert property (rdSetup ##0 (!armed && paddr[7:3] == 5'h00)
    |=> prdata[31:16] == 16'h0) else $error("window word too wide");
  a_arm_write: assert property (ctrlWr |=> armed == $past(pwdata[0]))
    else $error("arm bit not taken");
  a_arm_holds: assert property (!(psel && penable && pwrite) |=> $stable(armed))
    else $error("arm bit moved alone");
  a_mode_write: assert property (ctrlWr |=> traceMode == $past(pwdata[3:2]))
    else $error("mode not taken");
  a_read_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
endmodule // dtb_trace_checker
bind dtb_trace_buffer dtb_trace_checker chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .secured(secured), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .armed(armed), .traceMode(traceMode));
`default_nettype wire

// ### test/dtb_host_model.sv
/* Host CPU model: word transfers on APB.
   Assumes pready comes within 20 cycles. */
`timescale 1ns/10ps
`default_nettype none
module dtb_host_model (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic tmo
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb, tmo} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? 4'hF : 4'h0;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge ref_clk);
    tmo <= (n == 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // dtb_host_model
`default_nettype wire

// ### test/dtb_trace_buffer_bench.sv
/* Self-checking bench of the trace buffer store and readout.
   Assumes capture data high byte is the lower-address byte. */
`timescale 1ns/10ps
`default_nettype none
module dtb_trace_buffer_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic secured = 1'b0;
  logic capStrobe = 1'b0, capByte = 1'b0, capRead = 1'b0, capDest = 1'b0, capVector = 1'b0;
  logic [17:0] capAddr = '0;
  logic [15:0] capData = '0;
  logic psel, penable, pwrite, pready, tmo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int err_count = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  dtb_trace_buffer dut (.ref_clk(ref_clk), .rst_n(rst_n), .secured(secured),
    .capStrobe(capStrobe), .capAddr(capAddr), .capData(capData), .capByte(capByte),
    .capRead(capRead), .capDest(capDest), .capVector(capVector), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(), .prdata(prdata), .armed(), .traceMode());
  dtb_host_model host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .tmo(tmo));
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (tmo === 1'b1)
    begin
      err_count++;
      tally_and_finish;
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask
  // Gap after each strobe: detail mode needs a free cycle for its data line
  task cap(input logic [17:0] a, input logic [15:0] d, input logic [3:0] f);
    @(posedge ref_clk);
    capStrobe <= 1'b1;
    capAddr <= a;
    capData <= d;
    {capByte, capRead, capDest, capVector} <= f;
    @(posedge ref_clk);
    capStrobe <= 1'b0;
    @(posedge ref_clk);
  endtask
  task t_normal;
    wr(8'h08, 32'h3);
    cap(18'h2ABCD, 16'h0, 4'h1);
    cap(18'h12345, 16'h0, 4'h0);
    wr(8'h08, 32'h2);
    wr(8'h04, 32'h0);
    rdc(8'h0C, 32'h2);
    rdc(8'h00, 32'hABCD);
    rdc(8'h00, 32'hE);
    rdc(8'h00, 32'h2345);
    rdc(8'h00, 32'h1);
    rdc(8'h0C, 32'h2);
    $display("Test normal done");
  endtask
  task t_detail;
    wr(8'h08, 32'hB);
    cap(18'h10F00, 16'hA55A, 4'hC);
    cap(18'h31234, 16'hBEEF, 4'h0);
    wr(8'h08, 32'hA);
    wr(8'h04, 32'h0);
    rdc(8'h0C, 32'h4);
    rdc(8'h00, 32'h0F00);
    rdc(8'h00, 32'hD);
    rdc(8'h00, 32'h005A);
    rdc(8'h00, 32'h0);
    rdc(8'h00, 32'h1234);
    rdc(8'h00, 32'h3);
    rdc(8'h00, 32'hBEEF);
    rdc(8'h00, 32'h0);
    $display("Test detail done");
  endtask
  task t_wrap;
    wr(8'h08, 32'hF);
    rdc(8'h00, 32'hDEADBEEF);
    for (int i = 0; i < 66; i++)
      cap(i[17:0], 16'h0, 4'h0);
    wr(8'h08, 32'hE);
    wr(8'h04, 32'h0);
    rdc(8'h0C, 32'h40);
    rdc(8'h01, 32'h0);
    rdc(8'h00, 32'h2);
    rdc(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    for (int i = 2; i < 66; i++)
    begin
      rdc(8'h00, 32'(i));
      rdc(8'h00, 32'h0);
    end
    rdc(8'h00, 32'h2);
    // Reset mid-run: RAM and count must survive it
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h04, 32'h0);
    rdc(8'h00, 32'h0);
    wr(8'h08, 32'h2);
    rdc(8'h0C, 32'h40);
    secured <= 1'b1;
    rdc(8'h00, 32'h0);
    secured <= 1'b0;
    rdc(8'h00, 32'h2);
    $display("Test wrap done");
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_normal;
    t_detail;
    t_wrap;
    tally_and_finish;
  end
endmodule // dtb_trace_buffer_bench
`default_nettype wire
